//--- common/fslb_pkg.sv
/*
 * fslb_pkg: register offsets, bit positions and widths for the fault status
 * latch bank. Assumes the register access engine uses 8-bit register offsets.
 */
package fslb_pkg;

    localparam int          REG_W          = 8;
    localparam int          ADDR_W         = 8;
    localparam int          PG2_FLAGS      = 17;

    // register offsets
    localparam logic [7:0]  OFS_LIVE_ONE   = 8'h00;
    localparam logic [7:0]  OFS_LIVE_TWO   = 8'h01;
    localparam logic [7:0]  OFS_STICKY_ONE = 8'h04;
    localparam logic [7:0]  OFS_STICKY_TWO = 8'h05;

    // reset values
    localparam logic [7:0]  RST_FAULT      = 8'h00;
    localparam logic [7:0]  RD_UNMAPPED    = 8'h00;
    localparam logic [16:0] RST_PG2_SEEN   = 17'h00000;

    // live_fault_status_one fields
    localparam int          B1_SUPPLY_OFF  = 7;
    localparam int          B1_ORING_OFF   = 6;
    localparam int          B1_PG1         = 5;
    localparam int          B1_PG2         = 4;
    localparam int          B1_SR_OFF      = 3;
    localparam int          B1_FAST_OC     = 2;
    localparam int          B1_PRI_OC      = 1;
    localparam int          B1_SEC_OC      = 0;

    // live_fault_status_two fields
    localparam int          B2_CONTINUITY  = 7;
    localparam int          B2_UNDERVOLT   = 6;
    localparam int          B2_ORING_ACC   = 5;
    localparam int          B2_SUPPLY_UV   = 4;
    localparam int          B2_CORE_OV     = 3;
    localparam int          B2_SUPPLY_OV   = 2;
    localparam int          B2_LOAD_OV     = 1;
    localparam int          B2_LOCAL_OV    = 0;

    // positions in the second power-good ignore mask
    localparam int          M_SUPPLY_OFF   = 0;
    localparam int          M_ORING_OFF    = 1;
    localparam int          M_FAST_OC      = 2;
    localparam int          M_PRI_OC       = 3;
    localparam int          M_SEC_OC       = 4;
    localparam int          M_CONTINUITY   = 5;
    localparam int          M_UNDERVOLT    = 6;
    localparam int          M_ORING_ACC    = 7;
    localparam int          M_AC_SENSE     = 8;
    localparam int          M_EXT_FLAG     = 9;
    localparam int          M_CORE_OV      = 10;
    localparam int          M_SUPPLY_OV    = 11;
    localparam int          M_LOCAL_OV     = 12;
    localparam int          M_LOAD_OV      = 13;
    localparam int          M_OVERTEMP     = 14;
    localparam int          M_CHECKSUM     = 15;
    localparam int          M_EE_UNLOCKED  = 16;

endpackage : fslb_pkg

//--- src/fslb_fault_bank.sv
/*
 * fslb_fault_bank: live and sticky fault status registers with clear on read.
 * Assumes all fault inputs are synchronous to i_sys_clk and that the serial
 * interface engine presents each register read as a one-cycle strobe.
 */
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - sticky copy of each fault flag stays set after the fault disappears
// - serial read of sticky register clears only bits whose fault has gone
// - sticky bit sets only on a normal-to-fault rising transition
// - sticky register one at 0x04 mirrors live register one at 0x00
// - bit 7 shows supply off until the supply restarts
// - bit 6 shows the oring switch gate control is off
// - bit 5 is OR of seven first power-good flags
// - bit 4 is OR of seventeen second power-good flags
// - configuration mask excludes chosen flags from bit 4
// - bit 3 set by user rectifier disable, light load, or disabling flag
// - bit 2 reflects fast primary overcurrent comparator at 1.2 V
// - bit 1 primary accurate overcurrent, bit 0 secondary accurate overcurrent
// - clear on read applies only to reads via the serial interface
module fslb_fault_bank (
    input  wire logic        i_sys_clk,          // system clock, 25 MHz
    input  wire logic        i_sys_rst,          // async reset, active high
    input  wire logic        i_supply_off,       // supply off, pwm disabled
    input  wire logic        i_oring_switch_off, // oring switch gate drive off
    input  wire logic        i_fast_oc,          // fast overcurrent comparator out
    input  wire logic        i_primary_oc,       // primary accurate overcurrent
    input  wire logic        i_secondary_oc,     // secondary accurate overcurrent
    input  wire logic        i_continuity,       // voltage continuity fault
    input  wire logic        i_undervoltage,     // undervoltage trip
    input  wire logic        i_oring_acc_off,    // accurate oring reverse voltage
    input  wire logic        i_supply_uv,        // supply rail undervoltage
    input  wire logic        i_core_ov,          // core rail overvoltage
    input  wire logic        i_supply_ov,        // supply rail overvoltage
    input  wire logic        i_load_ov,          // load overvoltage trip
    input  wire logic        i_local_ov,         // local overvoltage trip
    input  wire logic        i_ac_line_sense,    // ac line sense fault
    input  wire logic        i_ext_flag,         // external flag input set
    input  wire logic        i_overtemp,         // overtemperature
    input  wire logic        i_checksum_fault,   // eeprom checksum fault
    input  wire logic        i_eeprom_unlocked,  // eeprom unlocked
    input  wire logic        i_sr_user_off,      // both rectifiers disabled by user
    input  wire logic        i_light_load,       // load below light-load threshold
    input  wire logic        i_sr_flag_off,      // a rectifier-disabling flag set
    input  wire logic [16:0] i_pg2_ignore,       // 1 = flag excluded from pg2
    input  wire logic        i_rd_strobe,        // register read request, 1 cycle
    input  wire logic [7:0]  i_rd_addr,          // register offset
    input  wire logic        i_rd_serial,        // read arrives via serial port
    output logic      [7:0]  o_rd_data,          // read data, registered
    output logic             o_rd_ack            // read data valid, 1 cycle
);

    ////////////////////////////////////////////////////////////////////////////
    // live fault vectors

    logic [16:0] pg2_src;
    logic [7:0]  live_one_next;
    logic [7:0]  live_two_next;
    logic [7:0]  live_one_reg;
    logic [7:0]  live_two_reg;
    logic [7:0]  prev_one_reg;
    logic [7:0]  prev_two_reg;
    logic [7:0]  sticky_one_reg;
    logic [7:0]  sticky_two_reg;
    logic [7:0]  sticky_one_next;
    logic [7:0]  sticky_two_next;
    logic [7:0]  clr_one;
    logic [7:0]  clr_two;

    // second power-good sources in mask bit order, so the ignore mask applies bit for bit
    always_comb begin
        pg2_src                             = '0;
        pg2_src[fslb_pkg::M_SUPPLY_OFF]     = i_supply_off;
        pg2_src[fslb_pkg::M_ORING_OFF]      = i_oring_switch_off;
        pg2_src[fslb_pkg::M_FAST_OC]        = i_fast_oc;
        pg2_src[fslb_pkg::M_PRI_OC]         = i_primary_oc;
        pg2_src[fslb_pkg::M_SEC_OC]         = i_secondary_oc;
        pg2_src[fslb_pkg::M_CONTINUITY]     = i_continuity;
        pg2_src[fslb_pkg::M_UNDERVOLT]      = i_undervoltage;
        pg2_src[fslb_pkg::M_ORING_ACC]      = i_oring_acc_off;
        pg2_src[fslb_pkg::M_AC_SENSE]       = i_ac_line_sense;
        pg2_src[fslb_pkg::M_EXT_FLAG]       = i_ext_flag;
        pg2_src[fslb_pkg::M_CORE_OV]        = i_core_ov;
        pg2_src[fslb_pkg::M_SUPPLY_OV]      = i_supply_ov;
        pg2_src[fslb_pkg::M_LOCAL_OV]       = i_local_ov;
        pg2_src[fslb_pkg::M_LOAD_OV]        = i_load_ov;
        pg2_src[fslb_pkg::M_OVERTEMP]       = i_overtemp;
        pg2_src[fslb_pkg::M_CHECKSUM]       = i_checksum_fault;
        pg2_src[fslb_pkg::M_EE_UNLOCKED]    = i_eeprom_unlocked;
    end

    always_comb begin
        live_one_next                           = '0;
        // supply stays flagged until the power stage reports a restart
        live_one_next[fslb_pkg::B1_SUPPLY_OFF]  = i_supply_off;
        live_one_next[fslb_pkg::B1_ORING_OFF]   = i_oring_switch_off;
        // aggregates are rebuilt from the inputs, not from other register bits
        live_one_next[fslb_pkg::B1_PG1]         = i_supply_off | i_fast_oc
                                                | i_primary_oc | i_secondary_oc
                                                | i_undervoltage | i_local_ov
                                                | i_load_ov;
        live_one_next[fslb_pkg::B1_PG2]         = |(pg2_src & ~i_pg2_ignore);
        live_one_next[fslb_pkg::B1_SR_OFF]      = i_sr_user_off | i_light_load
                                                | i_sr_flag_off;
        // threshold lives in the analog comparator; only its output is seen here
        live_one_next[fslb_pkg::B1_FAST_OC]     = i_fast_oc;
        live_one_next[fslb_pkg::B1_PRI_OC]      = i_primary_oc;
        live_one_next[fslb_pkg::B1_SEC_OC]      = i_secondary_oc;
    end

    // live register two has no aggregates; each bit is one fault input
    always_comb begin
        live_two_next                           = '0;
        live_two_next[fslb_pkg::B2_CONTINUITY]  = i_continuity;
        live_two_next[fslb_pkg::B2_UNDERVOLT]   = i_undervoltage;
        live_two_next[fslb_pkg::B2_ORING_ACC]   = i_oring_acc_off;
        live_two_next[fslb_pkg::B2_SUPPLY_UV]   = i_supply_uv;
        live_two_next[fslb_pkg::B2_CORE_OV]     = i_core_ov;
        live_two_next[fslb_pkg::B2_SUPPLY_OV]   = i_supply_ov;
        live_two_next[fslb_pkg::B2_LOAD_OV]     = i_load_ov;
        live_two_next[fslb_pkg::B2_LOCAL_OV]    = i_local_ov;
    end

    ////////////////////////////////////////////////////////////////////////////
    // live registers and edge history

    // live copy is resampled every cycle, so a read always returns current state
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            live_one_reg <= fslb_pkg::RST_FAULT;
            live_two_reg <= fslb_pkg::RST_FAULT;
        end else begin
            live_one_reg <= live_one_next;
            live_two_reg <= live_two_next;
        end
    end

    // previous sample for edge detection; a fault present out of reset counts
    // as a fresh rising edge because this starts at zero
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            prev_one_reg <= fslb_pkg::RST_FAULT;
            prev_two_reg <= fslb_pkg::RST_FAULT;
        end else begin
            prev_one_reg <= live_one_reg;
            prev_two_reg <= live_two_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sticky copies

    function automatic logic [7:0] clr_mask(input logic [7:0] ofs,
                                            input logic [7:0] target,
                                            input logic [7:0] live);
        // only serial reads clear, and never a bit whose fault is still live
        // a non-serial read is a side-band peek and must never lose a fault
        if (i_rd_strobe && i_rd_serial && ofs == target) begin
            clr_mask = ~live;
        end else begin
            clr_mask = '0;
        end
    endfunction

    always_comb begin
        clr_one         = clr_mask(i_rd_addr, fslb_pkg::OFS_STICKY_ONE, live_one_reg);
        clr_two         = clr_mask(i_rd_addr, fslb_pkg::OFS_STICKY_TWO, live_two_reg);
        // the clear looks at the live value held at the strobe, not the one arriving
        // a rising edge wins over a clear in the same cycle
        sticky_one_next = (sticky_one_reg & ~clr_one)
                        | (live_one_reg & ~prev_one_reg);
        sticky_two_next = (sticky_two_reg & ~clr_two)
                        | (live_two_reg & ~prev_two_reg);
    end

    // no write path exists; only reset or a serial read can lower a sticky bit
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            sticky_one_reg <= fslb_pkg::RST_FAULT;
            sticky_two_reg <= fslb_pkg::RST_FAULT;
        end else begin
            sticky_one_reg <= sticky_one_next;
            sticky_two_reg <= sticky_two_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read port; the value returned is the one before any clear takes effect

    // unmapped offsets read as zero and have no side effect
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_rd_data <= fslb_pkg::RD_UNMAPPED;
        end else if (i_rd_strobe) begin
            if (i_rd_addr == fslb_pkg::OFS_LIVE_ONE) begin
                o_rd_data <= live_one_reg;
            end else if (i_rd_addr == fslb_pkg::OFS_LIVE_TWO) begin
                o_rd_data <= live_two_reg;
            end else if (i_rd_addr == fslb_pkg::OFS_STICKY_ONE) begin
                o_rd_data <= sticky_one_reg;
            end else if (i_rd_addr == fslb_pkg::OFS_STICKY_TWO) begin
                o_rd_data <= sticky_two_reg;
            end else begin
                o_rd_data <= fslb_pkg::RD_UNMAPPED;
            end
        end
    end

    // ack is the strobe one cycle late, so strobes may come back to back
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_rd_ack <= 1'b0;
        end else begin
            o_rd_ack <= i_rd_strobe;
        end
    end

endmodule // fslb_fault_bank

`default_nettype wire

//--- verification/fslb_host_model.sv
/* fslb_host_model: host that reads the fault bank through the read port, serial or side-band.
   assumes the bench calls rd from its main sequence only. */
`timescale 1ns/1ps
`default_nettype none
module fslb_host_model (
    input  wire logic       i_clk,    // system clock
    input  wire logic       i_ack,    // read data valid
    input  wire logic [7:0] i_data,   // read data
    output logic            o_strobe, // read request
    output logic      [7:0] o_addr,   // register offset
    output logic            o_serial  // read arrives via serial port
);
    initial begin
        o_strobe = 1'b0;
        o_addr = 8'h00;
        o_serial = 1'b0;
    end
    // offset and source are inverted once taken so a stale value can never pass for a live one
    task automatic rd(input logic [7:0] a, input logic s, output logic [7:0] d,
                      output logic ok);
        @(posedge i_clk);
        #1;
        o_strobe = 1'b1;
        o_addr = a;
        o_serial = s;
        @(posedge i_clk);
        #1;
        o_strobe = 1'b0;
        o_addr = ~a;
        o_serial = ~s;
        // ack and data launched at the taking edge are settled here
        ok = i_ack;
        for (int n = 0; n < 4 && ok !== 1'b1; n++) begin
            @(posedge i_clk);
            #1;
            ok = i_ack;
        end
        d = i_data;
    endtask
endmodule // fslb_host_model
`default_nettype wire

//--- verification/fslb_fault_bank_checker.sv
/* fslb_fault_bank_checker: port assertions for the fault status bank.
   assumes one clock and reads no sooner than the second edge after reset. */
`timescale 1ns/1ps
`default_nettype none
module fslb_fault_bank_checker (
    input wire logic        i_sys_clk,          // system clock
    input wire logic        i_sys_rst,          // async reset, active high
    input wire logic        i_rd_strobe,        // read request
    input wire logic        i_rd_serial,        // read via serial port
    input wire logic        o_rd_ack,           // read data valid
    input wire logic        i_supply_off,       // supply off
    input wire logic        i_oring_switch_off, // oring gate off
    input wire logic        i_fast_oc,          // fast overcurrent
    input wire logic        i_primary_oc,       // primary overcurrent
    input wire logic        i_secondary_oc,     // secondary overcurrent
    input wire logic        i_continuity,       // voltage continuity
    input wire logic        i_undervoltage,     // undervoltage
    input wire logic        i_oring_acc_off,    // accurate oring off
    input wire logic        i_supply_uv,        // supply rail undervoltage
    input wire logic        i_core_ov,          // core rail overvoltage
    input wire logic        i_supply_ov,        // supply rail overvoltage
    input wire logic        i_load_ov,          // load overvoltage
    input wire logic        i_local_ov,         // local overvoltage
    input wire logic        i_ac_line_sense,    // ac line sense
    input wire logic        i_ext_flag,         // external flag input
    input wire logic        i_overtemp,         // overtemperature
    input wire logic        i_checksum_fault,   // checksum fault
    input wire logic        i_eeprom_unlocked,  // eeprom unlocked
    input wire logic        i_sr_user_off,      // rectifiers off by user
    input wire logic        i_light_load,       // light load
    input wire logic        i_sr_flag_off,      // rectifier-disabling flag
    input wire logic [16:0] i_pg2_ignore,       // pg2 ignore mask
    input wire logic [7:0]  i_rd_addr,          // register offset
    input wire logic [7:0]  o_rd_data           // read data
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);
    wire logic [16:0] flags = {i_eeprom_unlocked, i_checksum_fault, i_overtemp, i_load_ov,
        i_local_ov, i_supply_ov, i_core_ov, i_ext_flag, i_ac_line_sense, i_oring_acc_off,
        i_undervoltage, i_continuity, i_secondary_oc, i_primary_oc, i_fast_oc,
        i_oring_switch_off, i_supply_off};
    wire logic sr = i_sr_user_off | i_light_load | i_sr_flag_off;
    wire logic any1 = (|flags) | sr | i_supply_uv;
    wire logic pg1 = i_supply_off | i_fast_oc | i_primary_oc | i_secondary_oc | i_undervoltage
        | i_local_ov | i_load_ov;
    wire logic rd0 = i_rd_strobe && i_rd_addr == 8'h00;
    wire logic rd4 = i_rd_strobe && i_rd_addr == 8'h04;
    chk_ack_follows: assert property (i_rd_strobe |=> o_rd_ack) else $error("no ack");
    chk_ack_cause: assert property (o_rd_ack |-> $past(i_rd_strobe))
        else $error("stray ack");
    chk_unmapped_zero: assert property (i_rd_strobe && !(i_rd_addr inside {8'h00, 8'h01,
        8'h04, 8'h05}) |=> o_rd_data == 8'h00) else $error("unmapped read not zero");
    chk_live_gate: assert property (rd0 |=> o_rd_data[7:6] ==
        $past({i_supply_off, i_oring_switch_off}, 2)) else $error("bits 7:6 wrong");
    chk_pg_one: assert property (rd0 |=> o_rd_data[5] == $past(pg1, 2))
        else $error("bit 5 wrong");
    chk_pg_two: assert property (rd0 |=>
        o_rd_data[4] == $past(|(flags & ~i_pg2_ignore), 2)) else $error("bit 4 wrong");
    chk_sr_off: assert property (rd0 |=> o_rd_data[3] == $past(sr, 2))
        else $error("bit 3 wrong");
    chk_live_oc: assert property (rd0 |=> o_rd_data[2:0] ==
        $past({i_fast_oc, i_primary_oc, i_secondary_oc}, 2)) else $error("bits 2:0 wrong");
    chk_live_two: assert property (i_rd_strobe && i_rd_addr == 8'h01 |=> o_rd_data ==
        $past({i_continuity, i_undervoltage, i_oring_acc_off, i_supply_uv, i_core_ov,
        i_supply_ov, i_load_ov, i_local_ov}, 2)) else $error("live two wrong");
    chk_clear_read: assert property (rd4 && i_rd_serial && !any1 && $past(!any1)
        ##2 rd4 |=> o_rd_data == 8'h00) else $error("sticky not cleared");
    chk_nonserial_keep: assert property (rd4 && !i_rd_serial ##2 rd4 |=>
        (o_rd_data & $past(o_rd_data, 2)) == $past(o_rd_data, 2)) else $error("sticky lost");
endmodule // fslb_fault_bank_checker
bind fslb_fault_bank fslb_fault_bank_checker chk (.i_sys_clk, .i_sys_rst, .i_rd_strobe,
    .i_rd_serial, .o_rd_ack, .i_supply_off, .i_oring_switch_off, .i_fast_oc, .i_primary_oc,
    .i_secondary_oc, .i_continuity, .i_undervoltage, .i_oring_acc_off, .i_supply_uv,
    .i_core_ov, .i_supply_ov, .i_load_ov, .i_local_ov, .i_ac_line_sense, .i_ext_flag,
    .i_overtemp, .i_checksum_fault, .i_eeprom_unlocked, .i_sr_user_off, .i_light_load,
    .i_sr_flag_off, .i_pg2_ignore, .i_rd_addr, .o_rd_data);
`default_nettype wire

//--- verification/fslb_fault_bank_tb_top.sv
/* fslb_fault_bank_tb_top: self-checking bench for the fault status bank.
   assumes the host model and the bound checker are compiled alongside. */
`timescale 1ns/1ps
`default_nettype none
module fslb_fault_bank_tb_top;
    logic        i_sys_clk = 1'b0;
    logic        i_sys_rst = 1'b1;
    logic [20:0] flt = 21'h00000;
    logic [16:0] ign = 17'h00000;
    logic        strobe, serial, ack;
    logic [7:0]  addr, rdata;
    int          num_errors = 0;
    int          check_count = 0;
    int          cycles = 0;
    always #20 i_sys_clk = ~i_sys_clk;
    fslb_fault_bank dut (.i_sys_clk, .i_sys_rst, .i_supply_off(flt[0]),
        .i_oring_switch_off(flt[1]), .i_fast_oc(flt[2]), .i_primary_oc(flt[3]),
        .i_secondary_oc(flt[4]), .i_continuity(flt[5]), .i_undervoltage(flt[6]),
        .i_oring_acc_off(flt[7]), .i_ac_line_sense(flt[8]), .i_ext_flag(flt[9]),
        .i_core_ov(flt[10]), .i_supply_ov(flt[11]), .i_local_ov(flt[12]), .i_load_ov(flt[13]),
        .i_overtemp(flt[14]), .i_checksum_fault(flt[15]), .i_eeprom_unlocked(flt[16]),
        .i_sr_user_off(flt[17]), .i_light_load(flt[18]), .i_sr_flag_off(flt[19]),
        .i_supply_uv(flt[20]), .i_pg2_ignore(ign), .i_rd_strobe(strobe), .i_rd_addr(addr),
        .i_rd_serial(serial), .o_rd_data(rdata), .o_rd_ack(ack));
    fslb_host_model host (.i_clk(i_sys_clk), .i_ack(ack), .i_data(rdata), .o_strobe(strobe),
        .o_addr(addr), .o_serial(serial));
    ////////////////////////////////////////////////////////////////////////////////////////
    // flag bits 0..16 follow the ignore mask order, 17..19 rectifier causes, 20 supply uv
    function automatic logic [15:0] expect_regs(input logic [20:0] f, input logic [16:0] m);
        logic pg1;
        pg1 = f[0] | f[2] | f[3] | f[4] | f[6] | f[12] | f[13];
        return {f[0], f[1], pg1, |(f[16:0] & ~m), |f[19:17], f[2], f[3], f[4],
                f[5], f[6], f[7], f[20], f[10], f[11], f[13], f[12]};
    endfunction
    task automatic check(input logic [7:0] a, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch reg %h expected %h seen %h", a, exp, seen);
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic s, input logic [7:0] e);
        logic [7:0] d;
        logic       ok;
        host.rd(a, s, d, ok);
        if (ok !== 1'b1) d = ~e;
        check(a, d, e);
    endtask
    // two edges let the live register and then the sticky copy settle
    task automatic drive(input logic [20:0] f, input logic [16:0] m);
        @(posedge i_sys_clk);
        #1;
        flt = f;
        ign = m;
        repeat (2) @(posedge i_sys_clk);
    endtask
    task automatic t_reset_vals;
        logic [7:0] offs [8] = '{8'h00, 8'h01, 8'h04, 8'h05, 8'h02, 8'h03, 8'h06, 8'hff};
        foreach (offs[i]) rc(offs[i], 1'b1, 8'h00);
    endtask
    task automatic t_each_flag(input logic [16:0] m);
        logic [15:0] e;
        for (int k = 0; k < 21; k++) begin
            e = expect_regs(21'h1 << k, m);
            drive(21'h1 << k, m);
            rc(8'h00, 1'b1, e[15:8]);
            rc(8'h01, 1'b1, e[7:0]);
            drive(21'h0, m);
            rc(8'h00, 1'b1, 8'h00);
            rc(8'h05, 1'b1, e[7:0]);
            rc(8'h04, 1'b1, e[15:8]);
            rc(8'h04, 1'b1, 8'h00);
        end
    endtask
    task automatic t_persist;
        logic [15:0] e;
        e = expect_regs(21'h8, 17'h0);
        drive(21'h8, 17'h0);
        rc(8'h04, 1'b1, e[15:8]);
        rc(8'h04, 1'b1, e[15:8]);
        drive(21'h0, 17'h0);
        rc(8'h04, 1'b0, e[15:8]);
        rc(8'h04, 1'b0, e[15:8]);
        rc(8'h04, 1'b1, e[15:8]);
        rc(8'h04, 1'b1, 8'h00);
    endtask
    // reset drops the old primary bit; a fault held through reset is a fresh edge after it
    task automatic t_reset_mid;
        logic [15:0] e;
        e = expect_regs(21'h1, 17'h0);
        drive(21'h8, 17'h0);
        drive(21'h1, 17'h0);
        @(posedge i_sys_clk);
        #1;
        i_sys_rst = 1'b1;
        repeat (2) @(posedge i_sys_clk);
        #1;
        i_sys_rst = 1'b0;
        rc(8'h00, 1'b1, e[15:8]);
        rc(8'h04, 1'b1, e[15:8]);
        drive(21'h0, 17'h0);
        rc(8'h04, 1'b1, e[15:8]);
        rc(8'h04, 1'b1, 8'h00);
    endtask
    ////////////////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // the full run needs under 1000 cycles, so this limit only trips on a hang
    always @(posedge i_sys_clk) begin
        cycles++;
        if (cycles == 8000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (2) @(posedge i_sys_clk);
        #1;
        i_sys_rst = 1'b0;
        t_reset_vals();
        t_each_flag(17'h00000);
        t_each_flag(17'h1ffff);
        t_persist();
        t_reset_mid();
        tally_and_finish();
    end
endmodule // fslb_fault_bank_tb_top
`default_nettype wire
